// ---- rtl/fit_core.sv ----
// byte buffer, event flags, timer and soft power-down behind an avalon-mm slave
//
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Behaviour
// [RL1] one 64-byte buffer shared by host port and command logic, both directions
// [RL2] host write to data port stores a byte and advances write pointer
// [RL3] host read of data port returns head byte, then advances read pointer
// [RL4] 7-bit fill count readable, bytes currently held
// [RL5] host avoids buffer accesses a running command does not expect
// [RL6] writing clear bit resets pointers, zeroes count, clears overrun flag
// [RL7] overrun flag stays set until a buffer clear
// [RL8] near-full is 1 when 64 minus count is at most threshold
// [RL9] near-empty is 1 when count is at most 6-bit threshold
// [RL10] with enable set, rise of an alert flag raises interrupt pin
// [RL11] events shown on summary status bit and, if enabled, on interrupt pin; the status bit here shows enabled flags only
// [RL12] transmit-done flag set when sending moves to end-of-frame pattern
// [RL13] checksum-done flag set when checksum ready becomes 1
// [RL14] receive-done on end of received data; command-done when command goes idle
// [RL15] near-full and near-empty event flags set when alert becomes 1
// [RL16] error event flag set while any error register bit is 1
// [RL17] timer is a 12-bit prescaler with reload 0..4095 then down counter
// [RL18] 16-bit counter reload, value readable; 1 to 0 sets timer flag
// [RL19] host sets and clears timer flag; timer halts at 0 or restarts
// [RL20] go and halt bits, running status, auto start option
// [RL21] default period (2p+1)(r+1) clocks
// [RL22] alternative period (2p+2)(r+1) clocks
// [RL23] sleep bit enters power-down at once; all contents kept
// [RL24] after host writes 0, sleep bit stays 1 for 1024 clocks then clears
// [RL25] interrupt pin active while any enabled flag is set
module fit_core
  import fit_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic [5:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_eng_push,
  input  wire logic [7:0]  i_eng_data,
  input  wire logic        i_eng_pop,
  input  wire fit_evt_t    i_evt,
  output logic [7:0]       o_eng_head,
  output logic [6:0]       o_eng_fill,
  output logic [3:0]       o_cmd_code,
  output logic             o_sleep,
  output logic             o_irq
);
  // address match, used by every register decode
  function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
    return a == o;
  endfunction

  // storage and state
  logic [7:0]  mem [0:BUF_DEPTH-1];
  logic [5:0]  wr_ptr_r;
  logic [5:0]  rd_ptr_r;
  logic [6:0]  fill_r;
  logic        ovr_r;
  logic [3:0]  err_r;
  logic [5:0]  thr_r;
  logic [3:0]  cmd_r;
  logic        sleep_r;
  logic        exiting_r;
  logic [10:0] sleep_cnt_r;
  logic [6:0]  ev_r;
  logic [6:0]  ev_en_r;
  logic        crc_flag_r;
  logic        crc_en_r;
  logic        lo_prev_r;
  logic        hi_prev_r;
  logic        crc_prev_r;
  logic [11:0] div_r;
  logic        auto_r;
  logic        restart_r;
  logic        alt_r;
  logic [15:0] reload_r;
  logic        wait_r;
  logic [31:0] rdata_r;
  logic        irq_r;
  logic [7:0]  head_r;
  logic [15:0] tmr_value;
  logic        tmr_running;
  logic        tmr_expired;

  // bus phases: first cycle of a request is stalled, second commits
  wire       req     = i_avs_read || i_avs_write;
  wire       accept  = req && wait_r;
  wire       commit  = req && !wait_r;
  wire       wr_lo   = commit && i_avs_write && i_avs_byteenable[0];
  wire       wr_hi   = commit && i_avs_write && i_avs_byteenable[1];
  wire [7:0] wd      = i_avs_writedata[7:0];
  wire [5:0] adr     = i_avs_address;

  // register write strobes
  wire wr_opctl  = wr_lo && hit(adr, OFS_OPCTL);
  wire wr_even   = wr_lo && hit(adr, OFS_EVEN);
  wire wr_meven  = wr_lo && hit(adr, OFS_MEVEN);
  wire wr_evflg  = wr_lo && hit(adr, OFS_EVFLG);
  wire wr_mevflg = wr_lo && hit(adr, OFS_MEVFLG);
  wire wr_err    = wr_lo && hit(adr, OFS_ERR);
  wire wr_thr    = wr_lo && hit(adr, OFS_THR);
  wire wr_mctl   = wr_lo && hit(adr, OFS_MCTL);
  wire wr_tmode  = wr_lo && hit(adr, OFS_TMODE);
  wire wr_tdivlo = wr_lo && hit(adr, OFS_TDIVLO);
  wire wr_demod  = wr_lo && hit(adr, OFS_DEMOD);
  wire flush     = wr_lo && hit(adr, OFS_FILL) && wd[FILL_CLR];      // [RL6]

  // buffer access arbitration: host wins a same-cycle clash
  wire       host_push = wr_lo && hit(adr, OFS_DATA);                // [RL2]
  wire       host_pop  = commit && i_avs_read && hit(adr, OFS_DATA); // [RL3]
  wire       push      = host_push || i_eng_push;                    // [RL1] [RL5]
  wire       pop       = host_pop || i_eng_pop;                      // [RL1] [RL5]
  wire [7:0] push_data = host_push ? wd : i_eng_data;
  wire       full      = (fill_r == BUF_FULL);
  wire       do_push   = push && !full && !flush;
  wire       do_pop    = pop && (fill_r != 7'h00) && !flush;
  wire       overflow  = push && full && !flush;

  // fill count steps up on an accepted push and down on an accepted pop
  wire [6:0] fill_nxt = fill_r + {6'h00, do_push} - {6'h00, do_pop}; // [RL4]

  // alert levels from the current count
  wire near_empty = fill_r <= {1'b0, thr_r};                         // [RL9]
  wire near_full  = (BUF_FULL - fill_r) <= {1'b0, thr_r};            // [RL8]

  // error register view and event sources
  wire [4:0] err_view = {ovr_r, err_r};
  wire [6:0] ev_set;
  assign ev_set[EV_TIMER] = tmr_expired;                             // [RL18]
  assign ev_set[EV_ERR]   = |err_view;                               // [RL16]
  assign ev_set[EV_LOW]   = near_empty && !lo_prev_r;                // [RL15]
  assign ev_set[EV_HIGH]  = near_full && !hi_prev_r;                 // [RL15]
  assign ev_set[EV_IDLE]  = i_evt.cmd_finish;                        // [RL14]
  assign ev_set[EV_RX]    = i_evt.rx_end;                            // [RL14]
  assign ev_set[EV_TX]    = i_evt.tx_end;                            // [RL12]
  wire crc_set = i_evt.crc_ready && !crc_prev_r;                     // [RL13]

  // host set/clear of flags; hardware set always wins over a clear
  wire [6:0] ev_wr_set = (wr_evflg && wd[EV_SET]) ? wd[6:0] : 7'h00;   // [RL19]
  wire [6:0] ev_wr_clr = (wr_evflg && !wd[EV_SET]) ? wd[6:0] : 7'h00;  // [RL19]
  wire [6:0] ev_nxt    = (ev_r & ~ev_wr_clr) | ev_wr_set | ev_set;
  wire       crc_nxt   = (crc_flag_r && !(wr_mevflg && wd[MEV_CRC])) || crc_set;

  // pending interrupt: any enabled flag
  wire irq_pend = |(ev_r & ev_en_r) || (crc_flag_r && crc_en_r);    // [RL25] [RL10]

  // timer starts from host bit, or at end of transmission when auto is on
  wire tmr_go   = (wr_mctl && wd[MCTL_GO]) || (auto_r && i_evt.tx_end); // [RL20]
  wire tmr_halt = wr_mctl && wd[MCTL_HALT];                          // [RL20]
  wire fit_tmr_cfg_t tmr_cfg = '{divider: div_r, alt_div: alt_r,
                                 restart: restart_r, reload: reload_r};

  // read mux, latched on the stall cycle so data stands at the commit edge
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (1'b1)
      hit(adr, OFS_OPCTL):  rd_mux[7:0] = {3'h0, sleep_r, cmd_r};
      hit(adr, OFS_EVEN):   rd_mux[7:0] = {1'b0, ev_en_r};
      hit(adr, OFS_MEVEN):  rd_mux[MEV_CRC] = crc_en_r;
      hit(adr, OFS_EVFLG):  rd_mux[7:0] = {1'b0, ev_r};
      hit(adr, OFS_MEVFLG): rd_mux[MEV_CRC] = crc_flag_r;
      hit(adr, OFS_ERR):    rd_mux[4:0] = err_view;
      hit(adr, OFS_STAT): begin
        rd_mux[ST_LOW]    = near_empty;                              // [RL9]
        rd_mux[ST_HIGH]   = near_full;                               // [RL8]
        rd_mux[ST_TRUN]   = tmr_running;                             // [RL20]
        rd_mux[ST_IRQ]    = irq_pend;                                // [RL11]
        rd_mux[ST_CRCRDY] = i_evt.crc_ready;
      end
      hit(adr, OFS_DATA):   rd_mux[7:0] = mem[rd_ptr_r];             // [RL3]
      hit(adr, OFS_FILL):   rd_mux[6:0] = fill_r;                    // [RL4]
      hit(adr, OFS_THR):    rd_mux[5:0] = thr_r;
      hit(adr, OFS_TMODE): begin
        rd_mux[TM_AUTO]    = auto_r;
        rd_mux[TM_RESTART] = restart_r;
        rd_mux[3:0]        = div_r[11:8];
      end
      hit(adr, OFS_TDIVLO): rd_mux[7:0] = div_r[7:0];
      hit(adr, OFS_RELOAD): rd_mux[15:0] = reload_r;
      hit(adr, OFS_CVAL):   rd_mux[15:0] = tmr_value;                // [RL18]
      hit(adr, OFS_DEMOD):  rd_mux[DEMOD_ALT] = alt_r;
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  // buffer array, no reset: contents are dead once pointers move
  always_ff @(posedge i_clk) begin
    if (do_push) begin
      mem[wr_ptr_r] <= push_data;                                    // [RL2]
    end
  end

  // pointers, fill count and overrun
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      wr_ptr_r <= 6'h00;
      rd_ptr_r <= 6'h00;
      fill_r   <= 7'h00;
      ovr_r    <= 1'b0;
    end else if (flush) begin
      wr_ptr_r <= 6'h00;                                             // [RL6]
      rd_ptr_r <= 6'h00;
      fill_r   <= 7'h00;
      ovr_r    <= 1'b0;                                              // [RL7]
    end else begin
      wr_ptr_r <= wr_ptr_r + {5'h00, do_push};
      rd_ptr_r <= rd_ptr_r + {5'h00, do_pop};                        // [RL3]
      fill_r   <= fill_nxt;
      ovr_r    <= ovr_r || overflow;                                 // [RL7]
    end
  end

  // head byte for the command logic, one cycle behind the read pointer
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      head_r <= 8'h00;
    end else begin
      head_r <= mem[rd_ptr_r];
    end
  end

  // other error bits: sticky, host clears with ones; overrun not reachable here
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      err_r <= 4'h0;
    end else begin
      err_r <= (err_r & ~(wr_err ? wd[3:0] : 4'h0)) | i_evt.err;
    end
  end

  // event flags and edge history
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ev_r       <= 7'h00;
      crc_flag_r <= 1'b0;
      lo_prev_r  <= 1'b0;
      hi_prev_r  <= 1'b0;
      crc_prev_r <= 1'b0;
    end else begin
      ev_r       <= ev_nxt;                                          // [RL11]
      crc_flag_r <= crc_nxt;                                         // [RL13]
      lo_prev_r  <= near_empty;
      hi_prev_r  <= near_full;
      crc_prev_r <= i_evt.crc_ready;
    end
  end

  // host control registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ev_en_r   <= 7'h00;
      crc_en_r  <= 1'b0;
      thr_r     <= RST_THR;
      div_r     <= RST_DIV;
      auto_r    <= 1'b0;
      restart_r <= 1'b0;
      alt_r     <= 1'b0;
      reload_r  <= RST_RELOAD;
    end else begin
      if (wr_even) ev_en_r <= wd[6:0];                               // [RL10]
      if (wr_meven) crc_en_r <= wd[MEV_CRC];
      if (wr_thr) thr_r <= wd[5:0];
      if (wr_tmode) begin
        auto_r      <= wd[TM_AUTO];                                  // [RL20]
        restart_r   <= wd[TM_RESTART];                               // [RL19]
        div_r[11:8] <= wd[3:0];                                      // [RL17]
      end
      if (wr_tdivlo) div_r[7:0] <= wd;
      if (wr_demod) alt_r <= wd[DEMOD_ALT];                          // [RL22]
      if (wr_lo && hit(adr, OFS_RELOAD)) reload_r[7:0] <= wd;        // [RL18]
      if (wr_hi && hit(adr, OFS_RELOAD)) reload_r[15:8] <= i_avs_writedata[15:8];
    end
  end

  // command code: engine finishing returns it to idle
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cmd_r <= CMD_IDLE;
    end else if (i_evt.cmd_finish) begin
      cmd_r <= CMD_IDLE;                                             // [RL14]
    end else if (wr_opctl) begin
      cmd_r <= wd[3:0];
    end
  end

  // soft power-down: set at once, clear only after the exit delay
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      sleep_r     <= 1'b0;
      exiting_r   <= 1'b0;
      sleep_cnt_r <= 11'h000;
    end else if (wr_opctl && wd[OPCTL_SLEEP]) begin
      sleep_r     <= 1'b1;                                           // [RL23]
      exiting_r   <= 1'b0;
      sleep_cnt_r <= 11'h000;
    end else if (wr_opctl && sleep_r && !exiting_r) begin
      exiting_r   <= 1'b1;                                           // [RL24]
      sleep_cnt_r <= 11'h000;
    end else if (exiting_r) begin
      sleep_cnt_r <= sleep_cnt_r + 11'h001;
      if (sleep_cnt_r == SLEEP_EXIT_LAST) begin
        sleep_r   <= 1'b0;                                           // [RL24]
        exiting_r <= 1'b0;
      end
    end
  end

  // bus handshake and output flops
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h0000_0000;
      irq_r   <= 1'b0;
    end else begin
      wait_r  <= !accept;
      if (accept) rdata_r <= rd_mux;
      irq_r   <= irq_pend;                                           // [RL25] [RL11]
    end
  end

  // timer stages
  fit_timer u_timer (
    .i_clk     (i_clk),
    .i_rst_b   (i_rst_b),
    .i_go      (tmr_go),
    .i_halt    (tmr_halt),
    .i_cfg     (tmr_cfg),
    .o_value   (tmr_value),
    .o_running (tmr_running),
    .o_expired (tmr_expired)
  );

  assign o_avs_readdata    = rdata_r;
  assign o_avs_waitrequest = wait_r;
  assign o_eng_head        = head_r;
  assign o_eng_fill        = fill_r;
  assign o_cmd_code        = cmd_r;
  assign o_sleep           = sleep_r;
  assign o_irq             = irq_r;
endmodule

// ---- include/fit_pkg.sv ----
// shared constants and carrier types of the buffer, event and timer core
package fit_pkg;
  // buffer geometry
  localparam int unsigned BUF_DEPTH = 64;
  localparam logic [6:0] BUF_FULL = 7'h40;
  // register byte addresses
  localparam logic [5:0] OFS_OPCTL = 6'h00;
  localparam logic [5:0] OFS_EVEN = 6'h04;
  localparam logic [5:0] OFS_MEVEN = 6'h08;
  localparam logic [5:0] OFS_EVFLG = 6'h0c;
  localparam logic [5:0] OFS_MEVFLG = 6'h10;
  localparam logic [5:0] OFS_ERR = 6'h14;
  localparam logic [5:0] OFS_STAT = 6'h18;
  localparam logic [5:0] OFS_DATA = 6'h1c;
  localparam logic [5:0] OFS_FILL = 6'h20;
  localparam logic [5:0] OFS_THR = 6'h24;
  localparam logic [5:0] OFS_MCTL = 6'h28;
  localparam logic [5:0] OFS_TMODE = 6'h2c;
  localparam logic [5:0] OFS_TDIVLO = 6'h30;
  localparam logic [5:0] OFS_RELOAD = 6'h34;
  localparam logic [5:0] OFS_CVAL = 6'h38;
  localparam logic [5:0] OFS_DEMOD = 6'h3c;
  // field positions
  localparam int OPCTL_SLEEP = 4;
  localparam int EV_TIMER = 0;
  localparam int EV_ERR = 1;
  localparam int EV_LOW = 2;
  localparam int EV_HIGH = 3;
  localparam int EV_IDLE = 4;
  localparam int EV_RX = 5;
  localparam int EV_TX = 6;
  localparam int EV_SET = 7;
  localparam int MEV_CRC = 2;
  localparam int ERR_OVR = 4;
  localparam int ST_LOW = 0;
  localparam int ST_HIGH = 1;
  localparam int ST_TRUN = 3;
  localparam int ST_IRQ = 4;
  localparam int ST_CRCRDY = 5;
  localparam int FILL_CLR = 7;
  localparam int MCTL_HALT = 7;
  localparam int MCTL_GO = 6;
  localparam int TM_AUTO = 7;
  localparam int TM_RESTART = 4;
  localparam int DEMOD_ALT = 4;
  // reset values
  localparam logic [3:0] CMD_IDLE = 4'h0;
  localparam logic [5:0] RST_THR = 6'h08;
  localparam logic [11:0] RST_DIV = 12'h000;
  localparam logic [15:0] RST_RELOAD = 16'h0000;
  // soft power-down exit delay in clocks
  localparam int unsigned SLEEP_EXIT_CLKS = 1024;
  localparam logic [10:0] SLEEP_EXIT_LAST = 11'(SLEEP_EXIT_CLKS - 1);

  // events from the command, transceiver and checksum logic
  typedef struct packed {
    logic       tx_end;
    logic       rx_end;
    logic       crc_ready;
    logic       cmd_finish;
    logic [3:0] err;
  } fit_evt_t;

  // timer configuration
  typedef struct packed {
    logic [11:0] divider;
    logic        alt_div;
    logic        restart;
    logic [15:0] reload;
  } fit_tmr_cfg_t;
endpackage

// ---- rtl/fit_timer.sv ----
// two-stage reloadable timer: prescaler then down counter
`timescale 1ns/1ps
module fit_timer
  import fit_pkg::*;
(
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic         i_go,
  input  wire logic         i_halt,
  input  wire fit_tmr_cfg_t i_cfg,
  output logic [15:0]       o_value,
  output logic              o_running,
  output logic              o_expired
);
  logic [12:0] pre_r;
  logic [15:0] cnt_r;
  logic        run_r;
  logic        exp_r;

  // load 2p or 2p+1; counting down to 0 gives 2p+1 or 2p+2 clocks
  wire [12:0] pre_load = {i_cfg.divider, i_cfg.alt_div};   // [RL21] [RL22]
  wire        tick     = run_r && (pre_r == 13'h0000);

  // halt beats go so a stray double write leaves the timer stopped
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pre_r <= 13'h0000;
      cnt_r <= 16'h0000;
      run_r <= 1'b0;
      exp_r <= 1'b0;
    end else begin
      exp_r <= 1'b0;
      if (i_halt) begin
        run_r <= 1'b0;                                      // [RL20]
      end else if (i_go) begin
        run_r <= 1'b1;                                      // [RL20]
        pre_r <= pre_load;                                  // [RL17]
        cnt_r <= i_cfg.reload;                              // [RL18]
      end else if (run_r && !tick) begin
        pre_r <= pre_r - 13'h0001;                          // [RL17]
      end else if (tick) begin
        pre_r <= pre_load;
        if (cnt_r == 16'h0001) begin
          cnt_r <= 16'h0000;
          exp_r <= 1'b1;                                    // [RL18]
          run_r <= i_cfg.restart;                           // [RL19]
        end else if (cnt_r == 16'h0000) begin
          cnt_r <= i_cfg.reload;                            // [RL19]
          run_r <= i_cfg.restart;
        end else begin
          cnt_r <= cnt_r - 16'h0001;
        end
      end
    end
  end

  assign o_value   = cnt_r;
  assign o_running = run_r;
  assign o_expired = exp_r;
endmodule

// ---- tb/fit_core_checker.sv ----
// port-level assertions for the core
`timescale 1ns/1ps
module fit_core_checker
  import fit_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic [5:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  input  wire logic [31:0] o_avs_readdata,
  input  wire logic        o_avs_waitrequest,
  input  wire logic        i_eng_push,
  input  wire logic        i_eng_pop,
  input  wire logic [6:0]  o_eng_fill,
  input  wire logic        o_sleep
);
  logic [10:0] sleep_run_r;

  // saturating run length of the sleep bit
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || !o_sleep) begin
      sleep_run_r <= 11'h000;
    end else if (sleep_run_r != 11'h7ff) begin
      sleep_run_r <= sleep_run_r + 11'h001;
    end
  end

  // write commit edge
  wire wr_commit = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
  wire host_idle = !i_avs_write && !i_avs_read;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_req_waiting;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_single_ack;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence

  a_ack_one_wait: assert property (s_req_waiting |=> s_single_ack)
    else $error("answer not one cycle after request");
  a_no_spare_ack: assert property (
    $fell(o_avs_waitrequest) |-> $past(i_avs_read || i_avs_write))
    else $error("answer without a request");
  a_fill_bound: assert property (o_eng_fill <= BUF_FULL)
    else $error("fill count above depth");
  a_push_count: assert property (
    i_eng_push && !i_eng_pop && host_idle && o_eng_fill < BUF_FULL
    |=> o_eng_fill == $past(o_eng_fill) + 7'h01)
    else $error("push did not add one byte");
  a_pop_empty: assert property (
    i_eng_pop && !i_eng_push && host_idle && o_eng_fill == 7'h00 |=> o_eng_fill == 7'h00)
    else $error("empty pop changed the count");
  a_clear_zero: assert property (
    wr_commit && i_avs_address == OFS_FILL && i_avs_writedata[FILL_CLR] && !i_eng_push
    |=> ##[0:1] o_eng_fill == 7'h00)
    else $error("clear left bytes counted");
  a_sleep_enter: assert property (
    wr_commit && i_avs_address == OFS_OPCTL && i_avs_writedata[OPCTL_SLEEP] |=> o_sleep)
    else $error("sleep not set at once");
  a_sleep_exit_wait: assert property ($fell(o_sleep) |-> sleep_run_r >= 11'h400)
    else $error("sleep bit cleared early");
  a_fill_readback: assert property (
    i_avs_read && o_avs_waitrequest && i_avs_address == OFS_FILL && !i_eng_push && !i_eng_pop
    |=> o_avs_readdata == {25'h0, o_eng_fill})
    else $error("fill register read differs from count");
endmodule

bind fit_core fit_core_checker u_chk (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .i_eng_push(i_eng_push), .i_eng_pop(i_eng_pop),
  .o_eng_fill(o_eng_fill), .o_sleep(o_sleep));

// ---- tb/fit_eng_model.sv ----
// command-side model: pushes, pops and event pulses
`timescale 1ns/1ps
module fit_eng_model
  import fit_pkg::*;
(
  input  wire logic  i_clk,
  output logic       o_push,
  output logic [7:0] o_data,
  output logic       o_pop,
  output fit_evt_t   o_evt
);
  // quiet at start; host stays off the data port meanwhile
  initial {o_push, o_data, o_pop, o_evt} = 18'h0;

  // one byte per call; data then inverted so a stale byte never matches
  task automatic push_byte(input logic [7:0] b);
    @(posedge i_clk);
    o_push <= 1'b1;
    o_data <= b;
    @(posedge i_clk);
    o_push <= 1'b0;
    o_data <= ~b;
  endtask

  task automatic pop_byte;
    @(posedge i_clk);
    o_pop <= 1'b1;
    @(posedge i_clk);
    o_pop <= 1'b0;
  endtask

  // one-cycle event pulse
  task automatic pulse_evt(input fit_evt_t e);
    @(posedge i_clk);
    o_evt <= e;
    @(posedge i_clk);
    o_evt <= '0;
  endtask
endmodule

// ---- tb/fit_core_tb.sv ----
// self-checking bench for the core
`timescale 1ns/1ps
module fit_core_tb
  import fit_pkg::*;
();
  logic        clk, rst_b, avs_read, avs_write, avs_waitrequest;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0]  avs_byteenable, cmd_code;
  logic        eng_push, eng_pop, sleep, irq;
  logic [7:0]  eng_data, eng_head;
  logic [6:0]  eng_fill;
  fit_evt_t    evt;
  int          errors, cmp_count, cycles;

  fit_core DUT (.i_clk(clk), .i_rst_b(rst_b), .i_avs_address(avs_address),
    .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
    .i_avs_byteenable(avs_byteenable), .o_avs_readdata(avs_readdata),
    .o_avs_waitrequest(avs_waitrequest), .i_eng_push(eng_push), .i_eng_data(eng_data),
    .i_eng_pop(eng_pop), .i_evt(evt), .o_eng_head(eng_head), .o_eng_fill(eng_fill),
    .o_cmd_code(cmd_code), .o_sleep(sleep), .o_irq(irq));
  fit_eng_model u_eng (.i_clk(clk), .o_push(eng_push), .o_data(eng_data), .o_pop(eng_pop),
    .o_evt(evt));

  // 20 MHz clock
  always #25 clk = ~clk;

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      end_sim();
    end
  end

  task automatic end_sim;
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  // hold the request until an edge sees waitrequest low
  task automatic bus_go(input logic [5:0] a, input logic [31:0] d, input logic w);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus_go(a, d, 1'b1);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    bus_go(a, 32'h0, 1'b0);
    chk_word(rd, exp);
  endtask

  task automatic rd_bit(input logic [5:0] a, input int b, input logic exp);
    bus_go(a, 32'h0, 1'b0);
    chk_bit(rd[b], exp);
  endtask

  task automatic wait_irq(input logic v);
    while (irq !== v) @(posedge clk);
  endtask

  task automatic t_reset;
    rd_chk(OFS_THR, 32'h08);
    rd_chk(OFS_FILL, 32'h00);
    rd_chk(OFS_MCTL, 32'h00);
    rd_chk(6'h01, 32'h00);
    chk_word({28'h0, cmd_code}, 32'h0);
    $display("test reset done");
  endtask

  // fill, probe alerts, overrun, clear
  task automatic t_fifo;
    wr(OFS_EVFLG, 32'h7f);
    wr(OFS_EVEN, 32'h08);
    for (int k = 1; k <= 64; k++) begin
      wr(OFS_DATA, 32'(k));
      if (k == 8 || k == 9 || k == 55 || k == 56) begin
        bus_go(OFS_STAT, 32'h0, 1'b0);
        chk_bit(rd[ST_LOW], k <= 8);
        chk_bit(rd[ST_HIGH], k >= 56);
      end
    end
    chk_bit(irq, 1'b1);
    rd_chk(OFS_FILL, 32'h40);
    rd_bit(OFS_STAT, ST_IRQ, 1'b1);
    rd_bit(OFS_EVFLG, EV_HIGH, 1'b1);
    wr(OFS_DATA, 32'hee);
    rd_bit(OFS_ERR, ERR_OVR, 1'b1);
    rd_bit(OFS_EVFLG, EV_ERR, 1'b1);
    for (int k = 1; k <= 3; k++) rd_chk(OFS_DATA, 32'(k));
    wr(OFS_ERR, 32'hff);
    rd_bit(OFS_ERR, ERR_OVR, 1'b1);
    wr(OFS_FILL, 32'h80);
    rd_chk(OFS_FILL, 32'h00);
    rd_chk(OFS_ERR, 32'h00);
    wr(OFS_EVFLG, 32'h7f);
    repeat (3) @(posedge clk);
    chk_bit(irq, 1'b0);
    $display("test fifo done");
  endtask

  task automatic t_engine;
    u_eng.push_byte(8'ha5);
    u_eng.push_byte(8'h5a);
    rd_chk(OFS_DATA, 32'ha5);
    rd_chk(OFS_DATA, 32'h5a);
    wr(OFS_DATA, 32'h3c);
    repeat (3) @(posedge clk);
    chk_word({24'h0, eng_head}, 32'h3c);
    u_eng.pop_byte();
    rd_chk(OFS_FILL, 32'h00);
    $display("test engine done");
  endtask

  task automatic t_events;
    fit_evt_t pat [4] = '{8'h80, 8'h40, 8'h10, 8'h01};
    int       bits [4] = '{EV_TX, EV_RX, EV_IDLE, EV_ERR};
    wr(OFS_EVFLG, 32'h7f);
    for (int i = 0; i < 4; i++) begin
      u_eng.pulse_evt(pat[i]);
      repeat (2) @(posedge clk);
      rd_chk(OFS_EVFLG, 32'(1 << bits[i]));
      wr(OFS_ERR, 32'h0f);
      wr(OFS_EVFLG, 32'h7f);
    end
    u_eng.pulse_evt(8'h20);
    rd_bit(OFS_MEVFLG, MEV_CRC, 1'b1);
    $display("test events done");
  endtask

  // restart, divider 3, reload 9: spacing 70 clocks, 80 alt
  task automatic t_timer(input logic alt);
    time t0;
    wr(OFS_TDIVLO, 32'h03);
    wr(OFS_RELOAD, 32'h09);
    wr(OFS_TMODE, 32'h10);
    wr(OFS_DEMOD, {27'h0, alt, 4'h0});
    wr(OFS_EVEN, 32'h01);
    wr(OFS_EVFLG, 32'h7f);
    wr(OFS_MCTL, 32'h40);
    rd_bit(OFS_STAT, ST_TRUN, 1'b1);
    wait_irq(1'b1);
    t0 = $time;
    wr(OFS_EVFLG, 32'h01);
    wait_irq(1'b0);
    wait_irq(1'b1);
    chk_word(32'(($time - t0) / 50), alt ? 32'h50 : 32'h46);
    wr(OFS_MCTL, 32'h80);
    rd_bit(OFS_STAT, ST_TRUN, 1'b0);
    bus_go(OFS_CVAL, 32'h0, 1'b0);
    chk_bit(rd <= 32'h9, 1'b1);
    wr(OFS_EVFLG, 32'h7f);
    wr(OFS_EVFLG, 32'h81);
    rd_bit(OFS_EVFLG, EV_TIMER, 1'b1);
    wr(OFS_EVFLG, 32'h7f);
    wr(OFS_EVEN, 32'h00);
    $display("test timer done");
  endtask

  task automatic t_sleep;
    time t0;
    wr(OFS_THR, 32'h05);
    wr(OFS_OPCTL, 32'h10);
    @(posedge clk);
    chk_bit(sleep, 1'b1);
    wr(OFS_OPCTL, 32'h00);
    t0 = $time;
    while (sleep === 1'b1) @(posedge clk);
    chk_bit(($time - t0) / 50 >= 1023 && ($time - t0) / 50 <= 1026, 1'b1);
    rd_chk(OFS_THR, 32'h05);
    $display("test sleep done");
  endtask

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    {avs_address, avs_read, avs_write, avs_writedata} = 40'h0;
    avs_byteenable = 4'hf;
    errors = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_fifo();
    t_engine();
    t_events();
    t_timer(1'b0);
    t_timer(1'b1);
    t_sleep();
    end_sim();
  end
endmodule
